// ---- auv_alert_top.sv ----
// Threshold registers, hysteretic aux undervoltage alert and comparator overvoltage flag
//
// The address-and-strobe port was left to the implementer.
`timescale 1ns/1ps
`default_nettype none

module auv_alert_top (
    input  wire logic                       CLK_SYS_I,
    input  wire logic                       SRST_I,
    input  wire auv_pkg::auv_bus_req_t      BUS_REQ_I,
    output var  logic [auv_pkg::DATA_W-1:0] RDATA_O,
    input  wire auv_pkg::auv_aux_res_t      AUX_RES_I,
    input  wire auv_pkg::auv_comp_res_t     COMP_RES_I,
    output var  logic                       AUX_UV_ALERT_O,
    output var  logic                       COMP_OV_ALERT_O,
    output var  logic                       IRQ_O
);

    // ************************************************************
    // Behaviour notes
    // ************************************************************
    // Bus: strobes are taken at the rising edge where they stand high.
    // Read data appear one cycle after the read strobe, for one cycle.
    // Read data are zero in every cycle without a read.
    // Writes land at the strobe edge; a read in the next cycle sees them.
    // Unmapped writes are dropped and unmapped reads return zero.
    // Unused low bits of threshold words are dropped and read as zero.
    //
    // Aux results: only valid absolute results move the alert.
    // A result below the set level raises the alert.
    // A result at or above the clear level drops it.
    // Anything in between leaves the alert where it was.
    // The set compare wins, so a clear level below the set level
    // cannot make the alert toggle on one result.
    // A set level of zero can never be undercut by an unsigned result.
    //
    // Comparator results: each valid scan recomputes the flag; no band.
    // Threshold is all ones after reset, so the flag stays low.
    //
    // Interrupts: rise and fall of the alert and rise of the comparator
    // flag are the events. Status bits are sticky, cleared by writing
    // ones, and an event in the clear cycle wins. The interrupt output
    // follows the masked next status, so it moves in the same cycle as
    // the alert outputs and software sees both change together.
    //
    // Limitation: no check that software keeps clear at or above set;
    // a bad pair only degrades the hysteresis, it cannot lock the alert.

    // ************************************************************
    // Register state
    // ************************************************************
    logic [auv_pkg::UV_W-1:0]   uv_clear_q;
    logic [auv_pkg::UV_W-1:0]   uv_set_q;
    logic [auv_pkg::COMP_W-1:0] comp_ov_q;
    logic [auv_pkg::IRQ_N-1:0]  irq_stat_q;
    logic [auv_pkg::IRQ_N-1:0]  irq_stat_d;
    logic [auv_pkg::IRQ_N-1:0]  irq_mask_q;
    logic [auv_pkg::DATA_W-1:0] rdata_d;
    logic                       alert_q;
    logic                       alert_d;
    logic                       comp_ov_alert_q;
    logic                       comp_ov_alert_d;
    logic [auv_pkg::IRQ_N-1:0]  events;
    logic                       abs_valid;
    logic                       below_set;
    logic                       at_or_above_clear;
    logic                       comp_above;
    logic [auv_pkg::DATA_W-1:0] word_clear;
    logic [auv_pkg::DATA_W-1:0] word_set;
    logic [auv_pkg::DATA_W-1:0] word_comp;
    logic [auv_pkg::DATA_W-1:0] word_stat;
    logic [auv_pkg::DATA_W-1:0] word_mask;
    logic [auv_pkg::IRQ_N-1:0]  stat_clr;
    logic [auv_pkg::IRQ_N-1:0]  irq_pend;

    // Alert state; two states keep the hysteresis explicit
    typedef enum logic {
        UV_NORMAL,
        UV_LOW
    } auv_uv_state_t;

    auv_uv_state_t              uv_state_q;
    auv_uv_state_t              uv_state_d;

    // Write decode per register
    logic wr_clear;
    logic wr_set;
    logic wr_comp;
    logic wr_stat;
    logic wr_mask;

    assign wr_clear = BUS_REQ_I.wr && (BUS_REQ_I.addr == auv_pkg::OFS_UV_CLEAR);
    assign wr_set   = BUS_REQ_I.wr && (BUS_REQ_I.addr == auv_pkg::OFS_UV_SET);
    assign wr_comp  = BUS_REQ_I.wr && (BUS_REQ_I.addr == auv_pkg::OFS_COMP_OV);
    assign wr_stat  = BUS_REQ_I.wr && (BUS_REQ_I.addr == auv_pkg::OFS_IRQ_STAT);
    assign wr_mask  = BUS_REQ_I.wr && (BUS_REQ_I.addr == auv_pkg::OFS_IRQ_MASK);

    // ************************************************************
    // Threshold registers
    // ************************************************************

    // Clear level; low two bits of the word are dropped on write
    always_ff @(posedge CLK_SYS_I) begin
        if (SRST_I) begin
            uv_clear_q <= auv_pkg::UV_CLEAR_RST;
        end else if (wr_clear) begin
            uv_clear_q <= BUS_REQ_I.wdata[auv_pkg::UV_LSB +: auv_pkg::UV_W];
        end
    end

    // Set level; zero after reset keeps the check off
    always_ff @(posedge CLK_SYS_I) begin
        if (SRST_I) begin
            uv_set_q <= auv_pkg::UV_SET_RST;
        end else if (wr_set) begin
            uv_set_q <= BUS_REQ_I.wdata[auv_pkg::UV_LSB +: auv_pkg::UV_W];
        end
    end

    // Comparator overvoltage level; all ones means nothing can exceed it
    always_ff @(posedge CLK_SYS_I) begin
        if (SRST_I) begin
            comp_ov_q <= auv_pkg::COMP_OV_RST;
        end else if (wr_comp) begin
            comp_ov_q <= BUS_REQ_I.wdata[auv_pkg::COMP_LSB +: auv_pkg::COMP_W];
        end
    end

    // ************************************************************
    // Undervoltage alert with hysteresis
    // ************************************************************

    // Ratiometric results never touch the alert
    assign abs_valid = AUX_RES_I.valid && (AUX_RES_I.ref_sel == auv_pkg::REF_ABSOLUTE);

    // Compare terms kept apart so each threshold has one comparator
    assign below_set         = (AUX_RES_I.value < uv_set_q);
    assign at_or_above_clear = (AUX_RES_I.value >= uv_clear_q);

    // Set is checked first, so a misprogrammed clear below set still
    // leaves the alert high for low results rather than flickering
    always_comb begin
        uv_state_d = uv_state_q;
        case (uv_state_q)
            UV_NORMAL: begin
                if (abs_valid && below_set) begin
                    uv_state_d = UV_LOW;
                end
            end
            UV_LOW: begin
                if (abs_valid && !below_set && at_or_above_clear) begin
                    uv_state_d = UV_NORMAL;
                end
            end
            default: begin
                uv_state_d = UV_NORMAL;
            end
        endcase
    end

    // Alert starts inactive, matching the disabled check after reset
    always_ff @(posedge CLK_SYS_I) begin
        if (SRST_I) begin
            uv_state_q <= UV_NORMAL;
        end else begin
            uv_state_q <= uv_state_d;
        end
    end

    // Alert level now and next, used for output and edge events
    assign alert_q = (uv_state_q == UV_LOW);
    assign alert_d = (uv_state_d == UV_LOW);

    // ************************************************************
    // Comparator overvoltage flag
    // ************************************************************

    // Strictly above: a result equal to the threshold is not a fault
    assign comp_above = (COMP_RES_I.value > comp_ov_q);

    // Follows each comparator scan; holds between scans
    always_comb begin
        comp_ov_alert_d = comp_ov_alert_q;
        if (COMP_RES_I.valid) begin
            comp_ov_alert_d = comp_above;
        end
    end

    always_ff @(posedge CLK_SYS_I) begin
        if (SRST_I) begin
            comp_ov_alert_q <= 1'b0;
        end else begin
            comp_ov_alert_q <= comp_ov_alert_d;
        end
    end

    // ************************************************************
    // Interrupt status and mask
    // ************************************************************

    // Both edges of the undervoltage alert and the rise of the comparator flag are the events
    always_comb begin
        events                         = '0;
        events[auv_pkg::IRQ_UV_RISE]   = alert_d && !alert_q;
        events[auv_pkg::IRQ_UV_FALL]   = !alert_d && alert_q;
        events[auv_pkg::IRQ_COMP_OV]   = comp_ov_alert_d && !comp_ov_alert_q;
    end

    // Write-one-to-clear pattern taken from the bus word
    assign stat_clr = wr_stat ? BUS_REQ_I.wdata[auv_pkg::IRQ_N-1:0] : '0;

    // One sticky bit per event; set wins so no event is lost in the clear cycle
    for (genvar gi = 0; gi < auv_pkg::IRQ_N; gi++) begin : g_stat
        always_comb begin
            irq_stat_d[gi] = irq_stat_q[gi];
            if (stat_clr[gi]) begin
                irq_stat_d[gi] = 1'b0;
            end
            if (events[gi]) begin
                irq_stat_d[gi] = 1'b1;
            end
        end

        always_ff @(posedge CLK_SYS_I) begin
            if (SRST_I) begin
                irq_stat_q[gi] <= auv_pkg::IRQ_RST[gi];
            end else begin
                irq_stat_q[gi] <= irq_stat_d[gi];
            end
        end
    end

    always_ff @(posedge CLK_SYS_I) begin
        if (SRST_I) begin
            irq_mask_q <= auv_pkg::IRQ_RST;
        end else if (wr_mask) begin
            irq_mask_q <= BUS_REQ_I.wdata[auv_pkg::IRQ_N-1:0];
        end
    end

    // Pending events that software has enabled
    assign irq_pend = irq_stat_d & irq_mask_q;

    // Registered so the output is glitch free; built from next status
    // so it rises in the same cycle as the status bit
    always_ff @(posedge CLK_SYS_I) begin
        if (SRST_I) begin
            IRQ_O <= 1'b0;
        end else begin
            IRQ_O <= |irq_pend;
        end
    end

    // ************************************************************
    // Read path
    // ************************************************************

    // Each register's word laid out in place; unused bits read zero
    always_comb begin
        word_clear = '0;
        word_set   = '0;
        word_comp  = '0;
        word_stat  = '0;
        word_mask  = '0;
        word_clear[auv_pkg::UV_LSB +: auv_pkg::UV_W]     = uv_clear_q;
        word_set[auv_pkg::UV_LSB +: auv_pkg::UV_W]       = uv_set_q;
        word_comp[auv_pkg::COMP_LSB +: auv_pkg::COMP_W]  = comp_ov_q;
        word_stat[auv_pkg::IRQ_N-1:0]                    = irq_stat_q;
        word_mask[auv_pkg::IRQ_N-1:0]                    = irq_mask_q;
    end

    // Unmapped addresses read zero; data stand one cycle only
    always_comb begin
        rdata_d = '0;
        if (BUS_REQ_I.rd) begin
            case (BUS_REQ_I.addr)
                auv_pkg::OFS_UV_CLEAR: begin
                    rdata_d = word_clear;
                end
                auv_pkg::OFS_UV_SET: begin
                    rdata_d = word_set;
                end
                auv_pkg::OFS_COMP_OV: begin
                    rdata_d = word_comp;
                end
                auv_pkg::OFS_IRQ_STAT: begin
                    rdata_d = word_stat;
                end
                auv_pkg::OFS_IRQ_MASK: begin
                    rdata_d = word_mask;
                end
                default: begin
                    rdata_d = '0;
                end
            endcase
        end
    end

    always_ff @(posedge CLK_SYS_I) begin
        if (SRST_I) begin
            RDATA_O <= '0;
        end else begin
            RDATA_O <= rdata_d;
        end
    end

    // ************************************************************
    // Output drive
    // ************************************************************

    // Undervoltage alert pin copy, taken from the next state
    always_ff @(posedge CLK_SYS_I) begin
        if (SRST_I) begin
            AUX_UV_ALERT_O <= 1'b0;
        end else begin
            AUX_UV_ALERT_O <= alert_d;
        end
    end

    // Comparator flag pin copy, in step with its status event
    always_ff @(posedge CLK_SYS_I) begin
        if (SRST_I) begin
            COMP_OV_ALERT_O <= 1'b0;
        end else begin
            COMP_OV_ALERT_O <= comp_ov_alert_d;
        end
    end

endmodule : auv_alert_top

`default_nettype wire

// ---- auv_pkg.sv ----
// Package with register map, field layout, reset values and carrier types of the aux UV alert block
//
// Functional notes
// - Clear level is 14 bits at [15:2]; alert drops when result at or above it.
// - Set level is 14 bits at [15:2]; alert rises when result below it.
// - Levels apply only to aux results with reference select 1, absolute mode.
// - Set level zero never raises alert; both level registers reset to zero.
// - Set level register sits at offset 0x37, read-write, two low bits unused.
// - Comparator overvoltage level at 0x38, upper twelve bits, resets to all ones.

package auv_pkg;

    // ************************************************************
    // Bus and register map
    // ************************************************************
    localparam int ADDR_W = 8;
    localparam int DATA_W = 16;

    localparam logic [ADDR_W-1:0] OFS_UV_CLEAR  = 8'h36;
    localparam logic [ADDR_W-1:0] OFS_UV_SET    = 8'h37;
    localparam logic [ADDR_W-1:0] OFS_COMP_OV   = 8'h38;
    localparam logic [ADDR_W-1:0] OFS_IRQ_STAT  = 8'h40;
    localparam logic [ADDR_W-1:0] OFS_IRQ_MASK  = 8'h41;

    // ************************************************************
    // Field layout
    // ************************************************************
    localparam int UV_LSB   = 2;
    localparam int UV_W     = 14;
    localparam int COMP_LSB = 4;
    localparam int COMP_W   = 12;

    // ************************************************************
    // Reset values
    // ************************************************************
    localparam logic [UV_W-1:0]   UV_CLEAR_RST = 14'h0000;
    localparam logic [UV_W-1:0]   UV_SET_RST   = 14'h0000;
    localparam logic [COMP_W-1:0] COMP_OV_RST  = 12'hFFF;

    // ************************************************************
    // Interrupt status layout
    // ************************************************************
    localparam int IRQ_N        = 3;
    localparam int IRQ_UV_RISE  = 0;
    localparam int IRQ_UV_FALL  = 1;
    localparam int IRQ_COMP_OV  = 2;
    localparam logic [IRQ_N-1:0] IRQ_RST = 3'h0;

    // Reference selection code for absolute measurements
    localparam logic REF_ABSOLUTE = 1'b1;

    // ************************************************************
    // Carrier types
    // ************************************************************
    typedef struct packed {
        logic            valid;
        logic            ref_sel;
        logic [UV_W-1:0] value;
    } auv_aux_res_t;

    typedef struct packed {
        logic              valid;
        logic [COMP_W-1:0] value;
    } auv_comp_res_t;

    typedef struct packed {
        logic              wr;
        logic              rd;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
    } auv_bus_req_t;

endpackage : auv_pkg

// ---- auv_alert_sva.sv ----
// Concurrent checks on the ports of the aux undervoltage alert block
`timescale 1ns/1ps
`default_nettype none
module auv_alert_sva (
    input wire logic                       CLK_SYS_I,
    input wire logic                       SRST_I,
    input wire auv_pkg::auv_bus_req_t      BUS_REQ_I,
    input wire logic [auv_pkg::DATA_W-1:0] RDATA_O,
    input wire auv_pkg::auv_aux_res_t      AUX_RES_I,
    input wire auv_pkg::auv_comp_res_t     COMP_RES_I,
    input wire logic                       AUX_UV_ALERT_O,
    input wire logic                       COMP_OV_ALERT_O,
    input wire logic                       IRQ_O
);
    logic [13:0] set_q;
    logic [13:0] clr_q;
    logic [11:0] cmp_q;
    default clocking @(posedge CLK_SYS_I); endclocking
    default disable iff (SRST_I);
    // Shadow levels track bus writes, so checks compare against what software set
    always_ff @(posedge CLK_SYS_I) begin
        if (SRST_I) begin
            set_q <= 14'h0000;
            clr_q <= 14'h0000;
            cmp_q <= 12'hFFF;
        end else if (BUS_REQ_I.wr) begin
            if (BUS_REQ_I.addr == auv_pkg::OFS_UV_SET) set_q <= BUS_REQ_I.wdata[15:2];
            if (BUS_REQ_I.addr == auv_pkg::OFS_UV_CLEAR) clr_q <= BUS_REQ_I.wdata[15:2];
            if (BUS_REQ_I.addr == auv_pkg::OFS_COMP_OV) cmp_q <= BUS_REQ_I.wdata[15:4];
        end
    end
    // An absolute result taken this cycle
    sequence s_abs;
        AUX_RES_I.valid && AUX_RES_I.ref_sel;
    endsequence
    a_uv_rise: assert property (
        s_abs ##0 (AUX_RES_I.value < set_q) |=> AUX_UV_ALERT_O) else $error("uv alert not set");
    a_uv_fall: assert property (
        s_abs ##0 (AUX_RES_I.value >= set_q && AUX_RES_I.value >= clr_q) |=> !AUX_UV_ALERT_O)
        else $error("uv alert not cleared");
    a_uv_hold_band: assert property (
        s_abs ##0 (AUX_RES_I.value >= set_q && AUX_RES_I.value < clr_q) |=> $stable(AUX_UV_ALERT_O))
        else $error("uv alert moved in band");
    a_ratio_skip: assert property (
        !(AUX_RES_I.valid && AUX_RES_I.ref_sel) |=> $stable(AUX_UV_ALERT_O))
        else $error("uv alert moved without result");
    a_set_zero_off: assert property (
        set_q == 14'h0000 && !AUX_UV_ALERT_O |=> !AUX_UV_ALERT_O) else $error("uv alert with zero set");
    a_set_read: assert property (
        BUS_REQ_I.rd && BUS_REQ_I.addr == auv_pkg::OFS_UV_SET |=> RDATA_O == {set_q, 2'b00})
        else $error("set level read wrong");
    a_clr_read: assert property (
        BUS_REQ_I.rd && BUS_REQ_I.addr == auv_pkg::OFS_UV_CLEAR |=> RDATA_O == {clr_q, 2'b00})
        else $error("clear level read wrong");
    a_comp_flag: assert property (
        COMP_RES_I.valid |=> COMP_OV_ALERT_O == ($past(COMP_RES_I.value) > $past(cmp_q)))
        else $error("comparator flag wrong");
    a_comp_read: assert property (
        BUS_REQ_I.rd && BUS_REQ_I.addr == auv_pkg::OFS_COMP_OV |=> RDATA_O == {cmp_q, 4'h0})
        else $error("comparator level read wrong");
endmodule : auv_alert_sva
bind auv_alert_top auv_alert_sva auv_alert_sva_i (.CLK_SYS_I(CLK_SYS_I), .SRST_I(SRST_I),
    .BUS_REQ_I(BUS_REQ_I), .RDATA_O(RDATA_O), .AUX_RES_I(AUX_RES_I), .COMP_RES_I(COMP_RES_I),
    .AUX_UV_ALERT_O(AUX_UV_ALERT_O), .COMP_OV_ALERT_O(COMP_OV_ALERT_O), .IRQ_O(IRQ_O));
`default_nettype wire

// ---- tb_auv_alert_top.sv ----
// Self-checking testbench of the aux undervoltage alert block
`timescale 1ns/1ps
`default_nettype none
module tb_auv_alert_top;
    logic                       clk, srst, uv, ov, irq;
    logic [15:0]                rdata;
    auv_pkg::auv_bus_req_t      req;
    auv_pkg::auv_aux_res_t      aux;
    auv_pkg::auv_comp_res_t     cmp;
    int                         error_cnt, check_count;
    auv_alert_top auv_alert_top_i (.CLK_SYS_I(clk), .SRST_I(srst), .BUS_REQ_I(req),
        .RDATA_O(rdata), .AUX_RES_I(aux), .COMP_RES_I(cmp), .AUX_UV_ALERT_O(uv),
        .COMP_OV_ALERT_O(ov), .IRQ_O(irq));
    // 100 MHz clock
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    task automatic check(input string nm, input logic [15:0] seen, input logic [15:0] exp);
        check_count++;
        if (seen !== exp) begin
            error_cnt++;
            $display("ERROR %s expected %h seen %h", nm, exp, seen);
        end
    endtask : check
    // One-cycle strobes; read data is judged in the cycle after the strobe only
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge clk) req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        @(posedge clk) req <= '0;
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [15:0] exp);
        @(posedge clk) req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 16'h0000};
        @(posedge clk) req <= '0;
        #1 check("rdata", rdata, exp);
    endtask : rd
    // Alert is looked at one cycle after the result is taken
    task automatic res(input logic rs, input logic [13:0] v, input logic exp);
        @(posedge clk) aux <= '{valid: 1'b1, ref_sel: rs, value: v};
        @(posedge clk) aux <= '0;
        #1 check("uv_alert", {15'h0000, uv}, {15'h0000, exp});
    endtask : res
    task automatic t_reset_vals;
        rd(8'h36, 16'h0000);
        rd(8'h37, 16'h0000);
        rd(8'h38, 16'hFFF0);
        rd(8'h41, 16'h0000);
        rd(8'h50, 16'h0000);
        res(1'b1, 14'h0000, 1'b0);
    endtask : t_reset_vals
    task automatic t_reg_rw;
        wr(8'h37, 16'hFFFF);
        rd(8'h37, 16'hFFFC);
        wr(8'h36, 16'h5557);
        rd(8'h36, 16'h5554);
        wr(8'h38, 16'h800F);
        rd(8'h38, 16'h8000);
    endtask : t_reg_rw
    // Set 0x100, clear 0x200: walk through the band from both sides
    task automatic t_hyst;
        wr(8'h37, 16'h0400);
        wr(8'h36, 16'h0800);
        wr(8'h41, 16'h0003);
        rd(8'h41, 16'h0003);
        res(1'b1, 14'h00FF, 1'b1);
        #10 check("irq", {15'h0000, irq}, 16'h0001);
        res(1'b1, 14'h01FF, 1'b1);
        res(1'b0, 14'h3000, 1'b1);
        res(1'b1, 14'h0200, 1'b0);
        res(1'b1, 14'h0100, 1'b0);
        res(1'b0, 14'h0000, 1'b0);
        rd(8'h40, 16'h0003);
        wr(8'h40, 16'h0003);
        #1 check("irq", {15'h0000, irq}, 16'h0000);
        rd(8'h40, 16'h0000);
    endtask : t_hyst
    // Threshold 0x800: equal is not above, one more is
    task automatic t_comp;
        logic [11:0] v [2] = '{12'h800, 12'h801};
        wr(8'h38, 16'h8000);
        for (int i = 0; i < 2; i++) begin
            @(posedge clk) cmp <= '{valid: 1'b1, value: v[i]};
            @(posedge clk) cmp <= '0;
            #1 check("comp_ov", {15'h0000, ov}, i[15:0]);
        end
        rd(8'h40, 16'h0004);
    endtask : t_comp
    task automatic print_verdict;
        if (error_cnt == 0 && check_count > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : print_verdict
    // Watchdog: the whole sequence needs well under a thousand cycles
    initial begin
        repeat (5000) @(posedge clk);
        error_cnt++;
        print_verdict();
    end
    initial begin
        error_cnt = 0;
        check_count = 0;
        srst = 1'b1;
        req = '0;
        aux = '0;
        cmp = '0;
        repeat (16) @(posedge clk);
        srst <= 1'b0;
        t_reset_vals();
        t_reg_rw();
        t_hyst();
        t_comp();
        print_verdict();
    end
endmodule : tb_auv_alert_top
`default_nettype wire
